/* File: dt8_pkg.sv */
// Package for the dual 8-bit timer control block: register map, fields, reset values, timing.
// Assumes a 32-bit APB slave and a 100 MHz system clock.
package dt8_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL0_OFS  = 8'h00;
    localparam logic [7:0] STAT0_OFS  = 8'h04;
    localparam logic [7:0] CTRL1_OFS  = 8'h08;
    localparam logic [7:0] STAT1_OFS  = 8'h0C;
    localparam logic [7:0] CNT_OFS    = 8'h10;
    localparam logic [7:0] CMPA_OFS   = 8'h14;
    localparam logic [7:0] CMPB_OFS   = 8'h18;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MATCH_B_IRQ_EN_BIT = 7;
    localparam int MATCH_A_IRQ_EN_BIT = 6;
    localparam int WRAP_IRQ_EN_BIT    = 5;
    localparam int CLR_SRC_LSB        = 3;
    localparam int CNT_SRC_LSB        = 0;
    localparam int MATCH_B_FLAG_BIT   = 7;
    localparam int MATCH_A_FLAG_BIT   = 6;
    localparam int WRAP_FLAG_BIT      = 5;
    localparam int RSVD_BIT           = 4;
    localparam int PIN_ACT_B_LSB      = 2;
    localparam int PIN_ACT_A_LSB      = 0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] STAT_RST   = 8'h00;
    localparam logic [7:0] CNT_RST    = 8'h00;
    localparam logic [7:0] CMP_RST    = 8'hFF;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    // ------------------------------------------------------------
    // Prescaler ratios
    // ------------------------------------------------------------
    localparam int DIV_A = 8;
    localparam int DIV_B = 64;
    localparam int DIV_C = 8192;
    localparam int PRE_W = 13;
    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_STOP = 3'b000, SRC_D8 = 3'b001, SRC_D64 = 3'b010, SRC_D8192 = 3'b011,
        SRC_CASC = 3'b100, SRC_EXT_RISE = 3'b101, SRC_EXT_FALL = 3'b110, SRC_EXT_BOTH = 3'b111
    } dt8_src_t;
    typedef enum logic [1:0] {
        CLR_NONE = 2'b00, CLR_MA = 2'b01, CLR_MB = 2'b10, CLR_EXT = 2'b11
    } dt8_clr_t;
    typedef enum logic [1:0] {
        ACT_KEEP = 2'b00, ACT_LOW = 2'b01, ACT_HIGH = 2'b10, ACT_TOGGLE = 2'b11
    } dt8_act_t;
endpackage : dt8_pkg

/* File: dt8_timer.sv */
// Two-channel 8-bit timer: count source and clear selection, compare flags, output pins, requests.
// Assumes an APB master on the same clock; pins are synchronous to clk.
//
// Operation
// - Match B request needs flag and enable
// - Match A request needs flag and enable
// - Wrap request needs flag and enable
// - Clear field picks none, A, B, external
// - Source 000 stops; 001-011 prescaled falling edges
// - Channel zero 100 counts channel one wraps
// - Channel one 100 counts channel zero match A events
// - Sources 101-111 count external rise, fall, both
// - Match B sets status bit 7
// - Match A sets status bit 6
// - Wrap from FF to 00 sets bit 5
// - Flag clears after read-one then write-zero
// - Writing one to flags does nothing
// - Status bit 4 reserved, writes ignored
// - Bits 3:2 act on pin at B
// - Bits 1:0 act on pin at A
// - Coinciding matches: toggle, one, zero, keep
// - Match signalled at next count tick
// - Channel zero cascade: channel one clear setting ignored
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module dt8_timer
    import dt8_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  extClk,
    input  wire logic [1:0]  extReset,
    output logic      [1:0]  timerOutPin,
    output logic      [1:0]  matchAIrq,
    output logic      [1:0]  matchBIrq,
    output logic      [1:0]  wrapIrq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0][7:0]  ctrl;
        logic [1:0][7:0]  stat;
        logic [1:0][7:0]  cnt;
        logic [1:0][7:0]  cmpA;
        logic [1:0][7:0]  cmpB;
        logic [1:0][2:0]  armed;
        logic [1:0]       pin;
        logic [1:0]       extClkD;
        logic [1:0]       extRstD;
        logic [PRE_W-1:0] pre;
        logic [31:0]      rdata;
    } dt8_state_t;

    dt8_state_t st_reg, st_next;

    logic       access, wrEn, rdEn;
    logic [1:0] tick, matchA, matchB, wrap, doClr;
    logic       preTick8, preTick64, preTick8192;
    logic [31:0] rdVal;

    function automatic logic [1:0] reg_chan(input logic [7:0] a, input logic [7:0] base);
        reg_chan = {a == base + 8'h08, a == base};
    endfunction : reg_chan

    function automatic logic pin_act(input logic cur, input logic [1:0] a);
        case (a)
            ACT_LOW:    pin_act = 1'b0;
            ACT_HIGH:   pin_act = 1'b1;
            ACT_TOGGLE: pin_act = ~cur;
            default:    pin_act = cur;
        endcase
    endfunction : pin_act

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    assign access  = psel && penable;
    assign wrEn    = access && pwrite;
    assign rdEn    = access && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = access && !(paddr == CTRL0_OFS || paddr == STAT0_OFS || paddr == CTRL1_OFS ||
                     paddr == STAT1_OFS || paddr == CNT_OFS || paddr == CMPA_OFS || paddr == CMPB_OFS);
    // Read data stands in the access phase itself, as the bus samples it at the pready edge
    assign prdata  = rdEn ? rdVal : 32'h0000_0000;

    // Bits 9:8 of a status read note the channel read, used to arm the flag clear
    always_comb begin
        logic [1:0] rsel;
        rsel  = reg_chan(paddr, STAT0_OFS);
        rdVal = 32'h0000_0000;
        if (paddr == CTRL0_OFS)       rdVal = {24'h0, st_reg.ctrl[0]};
        else if (paddr == CTRL1_OFS)  rdVal = {24'h0, st_reg.ctrl[1]};
        else if (rsel[0])             rdVal = {22'h0, 2'b01, st_reg.stat[0]};
        else if (rsel[1])             rdVal = {22'h0, 2'b10, st_reg.stat[1]};
        else if (paddr == CNT_OFS)    rdVal = {16'h0, st_reg.cnt};
        else if (paddr == CMPA_OFS)   rdVal = {16'h0, st_reg.cmpA};
        else if (paddr == CMPB_OFS)   rdVal = {16'h0, st_reg.cmpB};
    end

    // Falling edge of each prescaled clock: MSB of the free-running divider going low
    assign preTick8    = st_reg.pre[2:0] == 3'h7;
    assign preTick64   = st_reg.pre[5:0] == 6'h3F;
    assign preTick8192 = st_reg.pre == 13'h1FFF;

    // Compares use current count, so a match is signalled only at the next tick after the count reaches the compare value
    generate
        for (genvar c = 0; c < 2; c++) begin : g_cmp
            assign matchA[c] = tick[c] && (st_reg.cnt[c] == st_reg.cmpA[c]);
            assign matchB[c] = tick[c] && (st_reg.cnt[c] == st_reg.cmpB[c]);
            assign wrap[c]   = tick[c] && (st_reg.cnt[c] == CNT_MAX) && !doClr[c];
            assign matchAIrq[c] = st_reg.stat[c][MATCH_A_FLAG_BIT] && st_reg.ctrl[c][MATCH_A_IRQ_EN_BIT];
            assign matchBIrq[c] = st_reg.stat[c][MATCH_B_FLAG_BIT] && st_reg.ctrl[c][MATCH_B_IRQ_EN_BIT];
            assign wrapIrq[c]   = st_reg.stat[c][WRAP_FLAG_BIT] && st_reg.ctrl[c][WRAP_IRQ_EN_BIT];
            assign timerOutPin[c] = st_reg.pin[c];
        end
    endgenerate

    // ------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] rise, fall;
        rise = extClk & ~st_reg.extClkD;
        fall = ~extClk & st_reg.extClkD;
        tick = 2'b00;
        // Channel one first: channel zero cascade depends on channel one wrap
        for (int i = 1; i >= 0; i--) begin
            case (dt8_src_t'(st_reg.ctrl[i][CNT_SRC_LSB +: 3]))
                SRC_D8:       tick[i] = preTick8;
                SRC_D64:      tick[i] = preTick64;
                SRC_D8192:    tick[i] = preTick8192;
                SRC_EXT_RISE: tick[i] = rise[i];
                SRC_EXT_FALL: tick[i] = fall[i];
                SRC_EXT_BOTH: tick[i] = rise[i] | fall[i];
                // Cascade uses the registered event, so the loop yields no tick, not a comb loop
                SRC_CASC:     tick[i] = st_reg.armed[1-i][i == 0 ? 2 : 0];
                default:      tick[i] = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clear selection
    // ------------------------------------------------------------
    always_comb begin
        logic cascade16;
        cascade16 = dt8_src_t'(st_reg.ctrl[0][CNT_SRC_LSB +: 3]) == SRC_CASC;
        for (int i = 0; i < 2; i++) begin
            case (dt8_clr_t'(st_reg.ctrl[i][CLR_SRC_LSB +: 2]))
                CLR_MA:  doClr[i] = matchA[i];
                CLR_MB:  doClr[i] = matchB[i];
                CLR_EXT: doClr[i] = extReset[i] && !st_reg.extRstD[i];
                default: doClr[i] = 1'b0;
            endcase
        end
        if (cascade16) begin
            doClr[1] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [1:0] actA, actB;
        st_next          = st_reg;
        st_next.pre      = st_reg.pre + PRE_W'(1);
        st_next.extClkD  = extClk;
        st_next.extRstD  = extReset;
        st_next.rdata    = 32'h0000_0000;
        for (int i = 0; i < 2; i++) begin
            st_next.armed[i] = {wrap[i], matchB[i], matchA[i]};
            // Counter
            if (doClr[i]) begin
                st_next.cnt[i] = CNT_RST;
            end else if (tick[i]) begin
                st_next.cnt[i] = st_reg.cnt[i] + 8'h01;
            end
            // Pin: the stronger action wins when both match together
            actA = matchA[i] ? st_reg.stat[i][PIN_ACT_A_LSB +: 2] : ACT_KEEP;
            actB = matchB[i] ? st_reg.stat[i][PIN_ACT_B_LSB +: 2] : ACT_KEEP;
            st_next.pin[i] = pin_act(st_reg.pin[i], (actA > actB) ? actA : actB);
            // Flag clear: a zero write only lands on a flag whose bit and channel bit (8 or 9) were one in the last read of any register
            if (wrEn && reg_chan(paddr, STAT0_OFS)[i]) begin
                st_next.stat[i][3:0] = pwdata[3:0];
                st_next.stat[i][RSVD_BIT] = 1'b0;
                for (int f = WRAP_FLAG_BIT; f <= MATCH_B_FLAG_BIT; f++) begin
                    // Event bits are {wrap, match B, match A}: map each flag to its own event
                    if (!pwdata[f] &&
                        st_reg.armed[i][(f == WRAP_FLAG_BIT) ? 2 : f - MATCH_A_FLAG_BIT] == 1'b0 &&
                        st_reg.stat[i][f] && st_reg.rdata[f] && st_reg.rdata[8 + i]) begin
                        st_next.stat[i][f] = 1'b0;
                    end
                end
            end
            // Hardware set wins over a same-cycle clear
            if (matchB[i]) st_next.stat[i][MATCH_B_FLAG_BIT] = 1'b1;
            if (matchA[i]) st_next.stat[i][MATCH_A_FLAG_BIT] = 1'b1;
            if (wrap[i])   st_next.stat[i][WRAP_FLAG_BIT]    = 1'b1;
            if (wrEn && reg_chan(paddr, CTRL0_OFS)[i]) st_next.ctrl[i] = pwdata[7:0];
        end
        // Counter and compare registers: byte 0 holds channel zero, byte 1 holds channel one
        if (wrEn && paddr == CNT_OFS)  st_next.cnt  = {pwdata[15:8], pwdata[7:0]};
        if (wrEn && paddr == CMPA_OFS) st_next.cmpA = {pwdata[15:8], pwdata[7:0]};
        if (wrEn && paddr == CMPB_OFS) st_next.cmpB = {pwdata[15:8], pwdata[7:0]};
        // Last read value kept to arm the flag clear; a write access drops it
        if (rdEn) begin
            st_next.rdata = rdVal;
        end else if (!access) begin
            st_next.rdata = st_reg.rdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg      <= '0;
            st_reg.cmpA <= {CMP_RST, CMP_RST};
            st_reg.cmpB <= {CMP_RST, CMP_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_IRQ_B: assert property (@(posedge clk) disable iff (!arst_n)
        matchBIrq[0] == (st_reg.stat[0][7] && st_reg.ctrl[0][7])) else $error("match B request wrong");
    AST_IRQ_A: assert property (@(posedge clk) disable iff (!arst_n)
        !st_reg.ctrl[1][6] |-> !matchAIrq[1]) else $error("match A request without enable");
    AST_IRQ_W: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(st_reg.stat[0][5]) |-> !wrapIrq[0]) else $error("wrap request after clear");
    AST_STOP: assert property (@(posedge clk) disable iff (!arst_n)
        (st_reg.ctrl[0][2:0] == 3'b000 && !wrEn) |=> $stable(st_reg.cnt[0])) else $error("stopped counter moved");
    AST_SET_A: assert property (@(posedge clk) disable iff (!arst_n)
        matchA[1] |=> st_reg.stat[1][6]) else $error("match A flag not set");
    AST_SET_W: assert property (@(posedge clk) disable iff (!arst_n)
        wrap[0] |=> st_reg.stat[0][5] && st_reg.cnt[0] == 8'h00) else $error("wrap flag not set");
    AST_NO_SET: assert property (@(posedge clk) disable iff (!arst_n)
        (!st_reg.stat[0][7] && !matchB[0]) |=> !st_reg.stat[0][7]) else $error("flag set by write");
    AST_RSVD: assert property (@(posedge clk) disable iff (!arst_n)
        !st_reg.stat[1][4]) else $error("reserved bit changed");
    AST_TOG: assert property (@(posedge clk) disable iff (!arst_n)
        (matchA[0] && st_reg.stat[0][1:0] == 2'b11) |=> timerOutPin[0] != $past(timerOutPin[0])) else $error("no toggle");
    AST_CASC_CLR: assert property (@(posedge clk) disable iff (!arst_n)
        st_reg.ctrl[0][2:0] == 3'b100 |-> !doClr[1]) else $error("channel one cleared in cascade");
endmodule : dt8_timer

/* File: dt8_pin_src.sv */
// External pin source: drives the count clock pins with a burst of whole pulses.
// Assumes the bench pulses start and holds chan steady until busy has come and gone; num is taken at start.
`timescale 1ns/1ps
module dt8_pin_src (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       start,
    input  wire logic       chan,
    input  wire logic [3:0] num,
    output logic      [1:0] extClk,
    output logic      [1:0] extReset,
    output logic            busy
);
    // ------------------------------------------------------------
    // Pulse burst
    // ------------------------------------------------------------
    logic [4:0] left;
    logic [1:0] ph;
    // No external clear stimulus is produced by this source
    assign extReset = 2'b00;
    // Each level lasts 3 clocks so the synchroniser always catches it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extClk <= 2'b00;
            busy   <= 1'b0;
            left   <= 5'h00;
            ph     <= 2'h0;
        end else if (!busy) begin
            if (start) begin
                busy <= 1'b1;
                left <= {num, 1'b0};
                ph   <= 2'h0;
            end
        end else if (ph == 2'h2) begin
            ph           <= 2'h0;
            extClk[chan] <= ~extClk[chan];
            left         <= left - 5'h01;
            busy         <= (left != 5'h01);
        end else begin
            ph <= ph + 2'h1;
        end
    end
endmodule : dt8_pin_src

/* File: tb.sv */
// Self-checking bench for the dual timer: APB register access, counting, flags, pins, requests.
// Assumes the slave answers through pready; read data is taken at the edge where pready is high.
`timescale 1ns/1ps
module tb;
    import dt8_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e; logic err;} dt8_row_t;
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, start = 0, chan = 0, er;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, q2;
    logic        pready, pslverr, busy;
    logic [3:0]  num = 4'h0;
    logic [1:0]  extClk, extReset, timerOutPin, matchAIrq, matchBIrq, wrapIrq;
    int          n_errors = 0, n_tests = 0, cyc = 0;
    int          dv[4] = '{8, DIV_A, DIV_B, DIV_C};
    dt8_row_t    rows[7] = '{
        '{CTRL1_OFS, 32'hFF, 32'hFF, 32'hFF, 1'b0}, '{STAT1_OFS, 32'hFF, 32'hEF, 32'h0F, 1'b0},
        '{CMPA_OFS, 32'h1234, 32'hFFFF, 32'h1234, 1'b0}, '{CMPB_OFS, 32'hABCD, 32'hFFFF, 32'hABCD, 1'b0},
        '{CNT_OFS, 32'h5A3C, 32'hFFFF, 32'h5A3C, 1'b0}, '{8'h1C, 32'hFF, 32'hFFFFFFFF, 32'h0, 1'b1},
        '{CTRL0_OFS, 32'h80, 32'hFF, 32'h80, 1'b0}};
    always #5 clk = ~clk;
    dt8_timer u_dt8_timer (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extClk(extClk), .extReset(extReset), .timerOutPin(timerOutPin), .matchAIrq(matchAIrq),
        .matchBIrq(matchBIrq), .wrapIrq(wrapIrq));
    dt8_pin_src u_dt8_pin_src (.clk(clk), .arst_n(arst_n), .start(start), .chan(chan), .num(num),
        .extClk(extClk), .extReset(extReset), .busy(busy));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("Counts: %0d errors, %0d tests", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // Setup, access until pready, data and response taken at that same edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        e = pslverr;
        r = prdata;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
        #1;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd
    // Burst of k pulses on one pin, then time for edge detection to land
    task automatic pulses(input logic c, input logic [3:0] k);
        int n;
        n = 0;
        @(posedge clk);
        start <= 1'b1; chan <= c; num <= k;
        @(posedge clk);
        start <= 1'b0;
        #1;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
        repeat (4) @(posedge clk);
    endtask : pulses
    always @(posedge clk) begin
        cyc++;
        if (cyc > 40000) begin
            n_errors++;
            $display("FAIL %0t timeout", $time);
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, q, er);
            chk(32'(er), 32'(rows[i].err), "slave error");
            rd(rows[i].a, q);
            chk(q & rows[i].m, rows[i].e, "readback");
        end
        // Second reset in mid-run, then every register back at its reset value
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'(4 * i), q);
            chk(q & ((i == 1 || i == 3) ? 32'hEF : 32'hFFFF), (i > 4) ? {16'h0, CMP_RST, CMP_RST} : 32'h0,
                "reset value");
        end
        chk({24'h0, timerOutPin, matchAIrq, matchBIrq, wrapIrq}, 32'h0, "reset outputs");
        // Same read spacing every time, so two prescaler periods give exactly two counts
        for (int s = 0; s < 4; s++) begin
            wr(CTRL0_OFS, 32'(s));
            rd(CNT_OFS, q);
            repeat (2 * dv[s] - 4) @(posedge clk);
            rd(CNT_OFS, q2);
            chk(32'(q2[7:0] - q[7:0]), (s == 0) ? 32'h0 : 32'h2, "prescaled count");
        end
        wr(CTRL0_OFS, 32'h4D);
        wr(CMPA_OFS, 32'h03);
        wr(STAT0_OFS, 32'h02);
        wr(CNT_OFS, 32'h0);
        pulses(1'b0, 4'h3);
        chk(32'(matchAIrq[0]), 32'h0, "no flag while equal");
        pulses(1'b0, 4'h1);
        chk(32'(matchAIrq[0]), 32'h1, "match A request");
        chk(32'(timerOutPin[0]), 32'h1, "pin driven high");
        rd(CNT_OFS, q);
        chk(q & 32'hFF, 32'h0, "clear on match A");
        rd(STAT0_OFS, q);
        chk(q & 32'hEF, 32'h42, "match A flag");
        wr(STAT0_OFS, 32'h02);
        chk(32'(matchAIrq[0]), 32'h0, "request drops");
        rd(STAT0_OFS, q);
        chk(q & 32'hEF, 32'h02, "flag cleared");
        pulses(1'b0, 4'h4);
        wr(STAT0_OFS, 32'h02);
        chk(32'(matchAIrq[0]), 32'h1, "zero write without read");
        wr(CTRL1_OFS, 32'h27);
        wr(CNT_OFS, 32'hFE00);
        pulses(1'b1, 4'h1);
        chk(32'(wrapIrq[1]), 32'h1, "wrap request");
        wr(CTRL1_OFS, 32'h07);
        chk(32'(wrapIrq[1]), 32'h0, "wrap request masked");
        // Only one channel cascades at a time, so the count loop never forms
        wr(CNT_OFS, 32'h0);
        wr(CTRL1_OFS, 32'h04);
        pulses(1'b0, 4'h8);
        rd(CNT_OFS, q);
        chk(q & 32'hFF00, 32'h0200, "count of channel zero matches");
        wr(CTRL1_OFS, 32'h0F);
        wr(CTRL0_OFS, 32'h04);
        wr(CNT_OFS, 32'hFF00);
        pulses(1'b1, 4'h1);
        rd(CNT_OFS, q);
        chk(q & 32'hFFFF, 32'h0101, "sixteen-bit carry");
        tally_and_finish();
    end
endmodule : tb
